// [hdl/tca_top.sv]
`timescale 1ns/1ps
// What this block does
// RULE1: data register page field returns/supplies physical page
// RULE2: lookup reports prior LRU; write ignores it
// RULE3: hit flag set on lookup hit
// RULE4: write with hit flag uses set choice
// RULE5: lookup hit reports hitting set
// RULE6: lookup searches linear page, updates both registers; the code updates the control register only on a hit
// RULE7: write allocates entry to control linear page
// RULE8: keep flag validates or invalidates target entry
// RULE9: attribute pairs select match on lookup
// RULE10: attribute pair 01 clears, 10 sets
// RULE11: command bit one lookup, zero write
// RULE12: software writes zeros to reserved bits
// RULE13: access only at privilege level zero
// RULE14: cache is 16KB four way, 256 lines
// RULE15: entry holds tag, line, valid, four dirty
// RULE16: three LRU bits per cache line
// RULE17: line picked by physical address 11:4
// RULE18: reads via flush buffer, writes via fill
// RULE19: TLB 32 entries four way, tag plus page
// RULE20: select control codes buffer, write, read, flush
// RULE21: no hit flag means own replacement; miss reads 0
module tca_top (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // move instruction to a test register
    input wire logic i_mov_req,
    input wire logic i_mov_wr,
    input wire logic [2:0] i_mov_sel,
    input wire logic [31:0] i_mov_wdata,
    // privilege of the issuing code
    input wire logic [1:0] i_cpl,
    input wire logic i_real_mode,
    // move answer
    output logic o_mov_done,
    output logic o_mov_fault,
    output logic [31:0] o_mov_rdata,
    output logic o_busy
);
    function automatic logic attr_match(input logic [1:0] pair, input logic stored);
        attr_match = (pair[1] & stored) | (pair[0] & ~stored);
    endfunction : attr_match

    function automatic logic [3:0] way_dec(input logic [1:0] w);
        way_dec = 4'h1 << w;
    endfunction : way_dec

    ////////////////////////////////////////////////////////////////////////////
    tca_pkg::tca_state_e state_r, state_nxt;
    logic [31:0] tdata_r, tctl_r, csel_r, ctag_r, cdata_r, rdata_r;
    logic [31:0] fill_r [4];
    logic [31:0] flush_r [4];
    logic [7:0] cnt_r;
    logic flush_tlb_r, busy_r, done_r, fault_r;
    logic priv_ok, req_ok, wr_ok, lookup;
    logic [2:0] tlb_addr;
    logic [7:0] c_addr;
    logic [3:0] tlb_we, ctag_we, cdat_we, match;
    logic [43:0] tlb_wdata;
    logic [43:0] tlb_rd [4];
    logic [24:0] ctag_wdata;
    logic [24:0] ctag_rd [4];
    logic [127:0] cdat_wdata;
    logic [127:0] cdat_rd [4];
    logic tlb_lru_we, c_lru_we, hit_any;
    logic [2:0] tlb_lru_rd, tlb_lru_new, tlb_lru_wdata, c_lru_rd, c_lru_new, c_lru_wdata;
    logic [1:0] tlb_victim, hit_way, tlb_way, c_way;
    tca_pkg::tca_cop_e cop;

    assign priv_ok = i_real_mode | (i_cpl == 2'h0); // RULE13
    assign req_ok = i_mov_req & (state_r == tca_pkg::ST_IDLE) & priv_ok; // RULE13
    assign wr_ok = req_ok & i_mov_wr;
    assign lookup = tctl_r[tca_pkg::TC_CMD_BIT]; // RULE11
    assign cop = tca_pkg::tca_cop_e'(csel_r[1:0]);
    assign c_way = csel_r[tca_pkg::CS_DW_LSB +: 2];
    assign tlb_addr = (state_r == tca_pkg::ST_FLUSH) ? cnt_r[2:0] : tctl_r[tca_pkg::PAGE_LSB +: 3];
    assign c_addr = (state_r == tca_pkg::ST_FLUSH) ? cnt_r : csel_r[tca_pkg::CS_LINE_LSB +: 8]; // RULE17

    ////////////////////////////////////////////////////////////////////////////
    // arrays: entry {valid, d, u, r, page, phys}; tag {valid, dirty, tag}
    for (genvar g = 0; g < tca_pkg::WAYS; g++) begin : g_way
        tca_mem #(.W(tca_pkg::TLB_ENT_W), .D(tca_pkg::TLB_ROWS), .AW(3)) u_tlb ( // RULE19
            .i_ref_clk(i_ref_clk), .i_we(tlb_we[g]), .i_addr(tlb_addr),
            .i_wdata(tlb_wdata), .o_rdata(tlb_rd[g]));
        tca_mem #(.W(tca_pkg::CTAG_W), .D(tca_pkg::CACHE_LINES), .AW(8)) u_ctag ( // RULE14 RULE15
            .i_ref_clk(i_ref_clk), .i_we(ctag_we[g]), .i_addr(c_addr),
            .i_wdata(ctag_wdata), .o_rdata(ctag_rd[g]));
        tca_mem #(.W(tca_pkg::LINE_W), .D(tca_pkg::CACHE_LINES), .AW(8)) u_cdat ( // RULE14 RULE15
            .i_ref_clk(i_ref_clk), .i_we(cdat_we[g]), .i_addr(c_addr),
            .i_wdata(cdat_wdata), .o_rdata(cdat_rd[g]));
        assign match[g] = tlb_rd[g][43] & (tlb_rd[g][39:20] == tctl_r[31:12]) // RULE6
            & attr_match(tctl_r[tca_pkg::TC_D_LSB +: 2], tlb_rd[g][42]) // RULE9
            & attr_match(tctl_r[tca_pkg::TC_U_LSB +: 2], tlb_rd[g][41]) // RULE9
            & attr_match(tctl_r[tca_pkg::TC_R_LSB +: 2], tlb_rd[g][40]); // RULE9
    end

    tca_mem #(.W(3), .D(tca_pkg::TLB_ROWS), .AW(3)) u_tlb_lru (
        .i_ref_clk(i_ref_clk), .i_we(tlb_lru_we), .i_addr(tlb_addr),
        .i_wdata(tlb_lru_wdata), .o_rdata(tlb_lru_rd));
    tca_mem #(.W(3), .D(tca_pkg::CACHE_LINES), .AW(8)) u_c_lru ( // RULE16
        .i_ref_clk(i_ref_clk), .i_we(c_lru_we), .i_addr(c_addr),
        .i_wdata(c_lru_wdata), .o_rdata(c_lru_rd));
    tca_plru u_tlb_plru (.i_lru(tlb_lru_rd), .i_way(tlb_way), .o_lru(tlb_lru_new), .o_victim(tlb_victim));
    tca_plru u_c_plru (.i_lru(c_lru_rd), .i_way(c_way), .o_lru(c_lru_new), .o_victim());

    assign hit_any = |match;
    always_comb begin
        hit_way = 2'h0;
        for (int w = tca_pkg::WAYS - 1; w >= 0; w--) begin
            if (match[w]) begin
                hit_way = 2'(w);
            end
        end
        if (lookup) begin
            tlb_way = hit_way;
        end else if (tdata_r[tca_pkg::TD_HIT_BIT]) begin
            tlb_way = tdata_r[tca_pkg::TD_SET_LSB +: 2]; // RULE4
        end else begin
            tlb_way = tlb_victim; // RULE21
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // array write controls
    always_comb begin
        tlb_we = 4'h0;
        ctag_we = 4'h0;
        cdat_we = 4'h0;
        tlb_lru_we = 1'b0;
        c_lru_we = 1'b0;
        // RULE7 RULE8 RULE10 RULE1
        tlb_wdata = {tctl_r[tca_pkg::TC_VALID_BIT], tctl_r[10], tctl_r[8], tctl_r[6],
                     tctl_r[31:12], tdata_r[31:12]};
        ctag_wdata = {ctag_r[tca_pkg::CT_VALID_BIT], ctag_r[tca_pkg::CT_DIRTY_LSB +: 4], ctag_r[31:12]};
        cdat_wdata = {fill_r[3], fill_r[2], fill_r[1], fill_r[0]}; // RULE18
        tlb_lru_wdata = tlb_lru_new;
        c_lru_wdata = c_lru_new;
        case (state_r)
            tca_pkg::ST_FLUSH: begin
                tlb_wdata = '0;
                ctag_wdata = '0;
                tlb_lru_wdata = 3'h0;
                c_lru_wdata = 3'h0;
                ctag_we = 4'hf;
                c_lru_we = 1'b1;
                if (flush_tlb_r && cnt_r <= tca_pkg::TLB_ROW_LAST) begin
                    tlb_we = 4'hf;
                    tlb_lru_we = 1'b1;
                end
            end
            tca_pkg::ST_TLB_EX: begin
                if (!lookup) begin
                    tlb_we = way_dec(tlb_way); // RULE7
                end
                tlb_lru_we = !lookup || hit_any;
            end
            tca_pkg::ST_C_EX: begin
                if (cop == tca_pkg::COP_WRITE) begin
                    ctag_we = way_dec(c_way);
                    cdat_we = way_dec(c_way);
                    c_lru_we = 1'b1; // RULE16
                end
            end
            default: begin
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            tca_pkg::ST_IDLE: begin
                if (wr_ok && i_mov_sel == tca_pkg::SEL_TLB_CTRL) begin
                    state_nxt = tca_pkg::ST_TLB_RD;
                end else if (wr_ok && i_mov_sel == tca_pkg::SEL_CACHE_SEL) begin
                    case (i_mov_wdata[1:0]) // RULE20
                        tca_pkg::COP_WRITE, tca_pkg::COP_READ: state_nxt = tca_pkg::ST_C_RD;
                        tca_pkg::COP_FLUSH: state_nxt = tca_pkg::ST_FLUSH;
                        default: state_nxt = tca_pkg::ST_IDLE;
                    endcase
                end
            end
            tca_pkg::ST_TLB_RD: state_nxt = tca_pkg::ST_TLB_EX;
            tca_pkg::ST_C_RD: state_nxt = tca_pkg::ST_C_EX;
            tca_pkg::ST_FLUSH: begin
                if (cnt_r == tca_pkg::FLUSH_LAST) begin
                    state_nxt = tca_pkg::ST_IDLE;
                end
            end
            default: state_nxt = tca_pkg::ST_IDLE;
        endcase
    end

    // reset runs a full invalidate of both arrays before taking moves
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_r <= tca_pkg::ST_FLUSH;
            cnt_r <= 8'h00;
            flush_tlb_r <= 1'b1;
            busy_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r <= (state_r == tca_pkg::ST_FLUSH) ? cnt_r + 8'h01 : 8'h00;
            if (state_nxt == tca_pkg::ST_IDLE) begin
                flush_tlb_r <= 1'b0;
            end
            busy_r <= (state_nxt != tca_pkg::ST_IDLE);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            done_r <= 1'b0;
            fault_r <= 1'b0;
        end else begin
            done_r <= (req_ok && state_nxt == tca_pkg::ST_IDLE)
                || (state_r != tca_pkg::ST_IDLE && state_nxt == tca_pkg::ST_IDLE && !flush_tlb_r);
            fault_r <= i_mov_req && (state_r == tca_pkg::ST_IDLE) && !priv_ok; // RULE13
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // tlb test registers
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            tdata_r <= tca_pkg::RST_REG;
        end else if (wr_ok && i_mov_sel == tca_pkg::SEL_TLB_DATA) begin
            tdata_r <= i_mov_wdata & tca_pkg::MASK_TLB_DATA;
        end else if (state_r == tca_pkg::ST_TLB_EX && lookup) begin
            tdata_r[tca_pkg::TD_LRU_LSB +: 3] <= tlb_lru_rd; // RULE2
            tdata_r[tca_pkg::TD_HIT_BIT] <= hit_any; // RULE3 RULE21
            if (hit_any) begin
                tdata_r[31:12] <= tlb_rd[hit_way][19:0]; // RULE1
                tdata_r[tca_pkg::TD_SET_LSB +: 2] <= hit_way; // RULE5
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            tctl_r <= tca_pkg::RST_REG;
        end else if (wr_ok && i_mov_sel == tca_pkg::SEL_TLB_CTRL) begin
            tctl_r <= i_mov_wdata & tca_pkg::MASK_TLB_CTRL;
        end else if (state_r == tca_pkg::ST_TLB_EX && lookup && hit_any) begin
            tctl_r[11:5] <= {1'b1, tlb_rd[hit_way][42], ~tlb_rd[hit_way][42], tlb_rd[hit_way][41], // RULE6
                             ~tlb_rd[hit_way][41], tlb_rd[hit_way][40], ~tlb_rd[hit_way][40]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cache test registers and line buffers
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            csel_r <= tca_pkg::RST_REG;
            cdata_r <= tca_pkg::RST_REG;
        end else begin
            if (wr_ok && i_mov_sel == tca_pkg::SEL_CACHE_SEL) begin
                csel_r <= i_mov_wdata & tca_pkg::MASK_CACHE_SEL;
            end
            if (wr_ok && i_mov_sel == tca_pkg::SEL_CACHE_DATA) begin
                cdata_r <= i_mov_wdata;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ctag_r <= tca_pkg::RST_REG;
        end else if (wr_ok && i_mov_sel == tca_pkg::SEL_CACHE_TAG) begin
            ctag_r <= i_mov_wdata & tca_pkg::MASK_CACHE_TAG;
        end else if (state_r == tca_pkg::ST_C_EX && cop == tca_pkg::COP_READ) begin
            ctag_r <= {ctag_rd[c_way][19:0], 1'b0, ctag_rd[c_way][24], c_lru_rd, ctag_rd[c_way][23:20], 3'h0};
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            for (int i = 0; i < 4; i++) begin
                fill_r[i] <= tca_pkg::RST_REG;
                flush_r[i] <= tca_pkg::RST_REG;
            end
        end else begin
            if (wr_ok && i_mov_sel == tca_pkg::SEL_CACHE_DATA && cop == tca_pkg::COP_BUF) begin
                fill_r[c_way] <= i_mov_wdata; // RULE18
            end
            if (state_r == tca_pkg::ST_C_EX && cop == tca_pkg::COP_READ) begin
                for (int i = 0; i < 4; i++) begin
                    flush_r[i] <= cdat_rd[c_way][32*i +: 32]; // RULE18
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            rdata_r <= tca_pkg::RST_REG;
        end else if (req_ok && !i_mov_wr) begin
            case (i_mov_sel)
                tca_pkg::SEL_TLB_DATA: rdata_r <= tdata_r;
                tca_pkg::SEL_TLB_CTRL: rdata_r <= tctl_r;
                tca_pkg::SEL_CACHE_SEL: rdata_r <= csel_r;
                tca_pkg::SEL_CACHE_TAG: rdata_r <= ctag_r;
                tca_pkg::SEL_CACHE_DATA: rdata_r <= (cop == tca_pkg::COP_BUF) ? flush_r[c_way] : cdata_r;
                default: rdata_r <= tca_pkg::RST_REG;
            endcase
        end
    end

    assign o_mov_done = done_r;
    assign o_mov_fault = fault_r;
    assign o_mov_rdata = rdata_r;
    assign o_busy = busy_r;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    logic tlb_ex_lk;
    assign tlb_ex_lk = (state_r == tca_pkg::ST_TLB_EX) && lookup;

    priv_fault_a: assert property (i_mov_req && state_r == tca_pkg::ST_IDLE && !priv_ok // RULE13
        |=> o_mov_fault && !o_mov_done && $stable(tdata_r) && $stable(tctl_r)) else $error("move at bad privilege");
    cmd_start_a: assert property (wr_ok && i_mov_sel == tca_pkg::SEL_TLB_CTRL // RULE11
        |=> state_r == tca_pkg::ST_TLB_RD ##1 state_r == tca_pkg::ST_TLB_EX ##1 o_mov_done) else $error("tlb op sequence");
    hit_flag_a: assert property (tlb_ex_lk |=> tdata_r[tca_pkg::TD_HIT_BIT] == $past(hit_any)) else $error("hit flag"); // RULE3
    miss_flag_a: assert property (tlb_ex_lk && !hit_any |=> !tdata_r[tca_pkg::TD_HIT_BIT]) else $error("miss flag"); // RULE21
    hit_set_a: assert property (tlb_ex_lk && hit_any // RULE5
        |=> tdata_r[tca_pkg::TD_SET_LSB +: 2] == $past(hit_way)) else $error("hit set report");
    phys_ret_a: assert property (tlb_ex_lk && hit_any // RULE1
        |=> tdata_r[31:12] == $past(tlb_rd[hit_way][19:0])) else $error("physical page return");
    prior_lru_a: assert property (tlb_ex_lk |=> tdata_r[9:7] == $past(tlb_lru_rd)) else $error("prior lru"); // RULE2
    set_pick_a: assert property (state_r == tca_pkg::ST_TLB_EX && !lookup && tdata_r[tca_pkg::TD_HIT_BIT] // RULE4
        |-> tlb_we == way_dec(tdata_r[3:2])) else $error("write set choice");
    keep_flag_a: assert property (state_r == tca_pkg::ST_TLB_EX && !lookup // RULE8
        |-> tlb_wdata[43] == tctl_r[11] && $onehot(tlb_we)) else $error("target valid bit");
    line_sel_a: assert property (state_r == tca_pkg::ST_C_EX |-> c_addr == csel_r[11:4]) else $error("line select"); // RULE17
    flush_len_a: assert property ($rose(state_r == tca_pkg::ST_FLUSH) // RULE20
        |-> ##255 state_r == tca_pkg::ST_FLUSH ##1 state_r == tca_pkg::ST_IDLE) else $error("flush length");

    lookup_hit_c: cover property (tlb_ex_lk && hit_any);
    tlb_write_c: cover property (state_r == tca_pkg::ST_TLB_EX && !lookup);
    cache_read_c: cover property (state_r == tca_pkg::ST_C_EX && cop == tca_pkg::COP_READ);
endmodule : tca_top

// [hdl/tca_pkg.sv]
package tca_pkg;
    // test register selects carried with a move instruction
    localparam logic [2:0] SEL_CACHE_DATA = 3'h3;
    localparam logic [2:0] SEL_CACHE_TAG = 3'h4;
    localparam logic [2:0] SEL_CACHE_SEL = 3'h5;
    localparam logic [2:0] SEL_TLB_CTRL = 3'h6;
    localparam logic [2:0] SEL_TLB_DATA = 3'h7;

    localparam logic [31:0] RST_REG = 32'h0000_0000;
    // bits that hold state; the rest read as zero
    localparam logic [31:0] MASK_TLB_DATA = 32'hffff_f39c;
    localparam logic [31:0] MASK_TLB_CTRL = 32'hffff_ffe1;
    localparam logic [31:0] MASK_CACHE_SEL = 32'h0000_0fff;
    localparam logic [31:0] MASK_CACHE_TAG = 32'hffff_f7f8;

    // field positions
    localparam int PAGE_LSB = 12;
    localparam int TD_LRU_LSB = 7;
    localparam int TD_HIT_BIT = 4;
    localparam int TD_SET_LSB = 2;
    localparam int TC_VALID_BIT = 11;
    localparam int TC_D_LSB = 9;
    localparam int TC_U_LSB = 7;
    localparam int TC_R_LSB = 5;
    localparam int TC_CMD_BIT = 0;
    localparam int CS_LINE_LSB = 4;
    localparam int CS_DW_LSB = 2;
    localparam int CT_VALID_BIT = 10;
    localparam int CT_LRU_LSB = 7;
    localparam int CT_DIRTY_LSB = 3;

    // array geometry
    localparam int WAYS = 4;
    localparam int TLB_ROWS = 8;
    localparam int TLB_ENT_W = 44;
    localparam int CACHE_LINES = 256;
    localparam int CTAG_W = 25;
    localparam int LINE_W = 128;
    localparam logic [7:0] FLUSH_LAST = 8'hff;
    localparam logic [7:0] TLB_ROW_LAST = 8'h07;

    typedef enum logic [1:0] {
        COP_BUF = 2'h0,
        COP_WRITE = 2'h1,
        COP_READ = 2'h2,
        COP_FLUSH = 2'h3
    } tca_cop_e;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_TLB_RD = 6'h02,
        ST_TLB_EX = 6'h04,
        ST_C_RD = 6'h08,
        ST_C_EX = 6'h10,
        ST_FLUSH = 6'h20
    } tca_state_e;
endpackage : tca_pkg

// [hdl/tca_mem.sv]
`timescale 1ns/1ps
module tca_mem #(
    parameter int W = 8,
    parameter int D = 16,
    parameter int AW = 4
) (
    // clock
    input wire logic i_ref_clk,
    // write port
    input wire logic i_we,
    input wire logic [AW-1:0] i_addr,
    input wire logic [W-1:0] i_wdata,
    // registered read data, old contents on a write
    output logic [W-1:0] o_rdata
);
    logic [W-1:0] mem_r [D];

    always_ff @(posedge i_ref_clk) begin
        if (i_we) begin
            mem_r[i_addr] <= i_wdata;
        end
        o_rdata <= mem_r[i_addr];
    end
endmodule : tca_mem

// [hdl/tca_plru.sv]
`timescale 1ns/1ps
module tca_plru (
    // current state and accessed way
    input wire logic [2:0] i_lru,
    input wire logic [1:0] i_way,
    // state after the access, way to replace now
    output logic [2:0] o_lru,
    output logic [1:0] o_victim
);
    always_comb begin
        o_lru = i_lru;
        case (i_way)
            2'h0: begin
                o_lru[0] = 1'b1;
                o_lru[1] = 1'b1;
            end
            2'h1: begin
                o_lru[0] = 1'b1;
                o_lru[1] = 1'b0;
            end
            2'h2: begin
                o_lru[0] = 1'b0;
                o_lru[2] = 1'b1;
            end
            default: begin
                o_lru[0] = 1'b0;
                o_lru[2] = 1'b0;
            end
        endcase
        if (i_lru[0]) begin
            o_victim = i_lru[2] ? 2'h3 : 2'h2;
        end else begin
            o_victim = i_lru[1] ? 2'h1 : 2'h0;
        end
    end
endmodule : tca_plru

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_mov_req = 1'b0;
    logic i_mov_wr = 1'b0;
    logic [2:0] i_mov_sel = 3'h0;
    logic [31:0] i_mov_wdata = 32'h0000_0000;
    logic [1:0] i_cpl = 2'h0;
    logic i_real_mode = 1'b0;
    logic o_mov_done;
    logic o_mov_fault;
    logic [31:0] o_mov_rdata;
    logic o_busy;
    int fails = 0;
    int samples_checked = 0;
    logic [31:0] last_q;
    logic last_f;
    logic [66:0] rows [0:5];
    logic [32:0] looks [0:3];

    tca_top DUT (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_mov_req(i_mov_req), .i_mov_wr(i_mov_wr),
        .i_mov_sel(i_mov_sel), .i_mov_wdata(i_mov_wdata), .i_cpl(i_cpl), .i_real_mode(i_real_mode),
        .o_mov_done(o_mov_done), .o_mov_fault(o_mov_fault), .o_mov_rdata(o_mov_rdata), .o_busy(o_busy)
    );

    initial begin
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
        samples_checked++;
        if ((got & mask) !== (exp & mask)) begin
            fails++;
            $display("BAD %0t word got %h exp %h mask %h", $time, got, exp, mask);
        end
    endtask : chk_word

    task automatic chk_flag(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t flag got %b exp %b", $time, got, exp);
        end
    endtask : chk_flag

    // one move, waits for done or fault
    task automatic mov(input logic wr, input logic [2:0] sel, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        #1;
        i_mov_req = 1'b1;
        i_mov_wr = wr;
        i_mov_sel = sel;
        i_mov_wdata = d;
        @(posedge i_ref_clk);
        #1;
        i_mov_req = 1'b0;
        while (o_mov_done !== 1'b1 && o_mov_fault !== 1'b1 && n < 400) begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        if (n >= 400) begin
            fails++;
            $display("BAD %0t move never answered", $time);
        end
        last_q = o_mov_rdata;
        last_f = o_mov_fault;
    endtask : mov

    task automatic rd_chk(input logic [2:0] sel, input logic [31:0] exp, input logic [31:0] mask);
        mov(1'b0, sel, 32'h0000_0000);
        chk_word(last_q, exp, mask);
    endtask : rd_chk

    // waits out a reset or cache flush
    task automatic wait_idle;
        int n;
        n = 0;
        while (o_busy !== 1'b0 && n < 400) begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        chk_flag(o_busy, 1'b0);
    endtask : wait_idle

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(4000 * 100);
        fails++;
        $display("BAD %0t watchdog expired", $time);
        give_verdict();
    end

    initial begin
        // sel, write value, readback; cache data reads the flush buffer while control is 00
        rows[0] = {3'h3, 32'hffff_ffff, 32'h0000_0000};
        rows[1] = {3'h4, 32'hffff_ffff, 32'hffff_f7f8};
        rows[2] = {3'h5, 32'hffff_fff0, 32'h0000_0ff0};
        rows[3] = {3'h7, 32'hffff_f39c, 32'hffff_f39c};
        rows[4] = {3'h1, 32'hffff_ffff, 32'h0000_0000};
        rows[5] = {3'h3, 32'h1234_5678, 32'h0000_0000};
        // lookup control, expected hit
        looks[0] = {32'h1234_57e1, 1'b1};
        looks[1] = {32'h1234_53e1, 1'b0};
        looks[2] = {32'h1234_5661, 1'b0};
        looks[3] = {32'h1234_56e1, 1'b1};
        repeat (3) @(posedge i_ref_clk);
        #1;
        chk_flag(o_busy, 1'b1);
        chk_flag(o_mov_done | o_mov_fault, 1'b0);
        chk_word(o_mov_rdata, 32'h0000_0000, 32'hffff_ffff);
        i_rst = 1'b0;
        wait_idle();
        foreach (rows[i]) begin
            mov(1'b1, rows[i][66:64], rows[i][63:32]);
            rd_chk(rows[i][66:64], rows[i][31:0], 32'hffff_ffff);
        end
        // privilege
        i_cpl = 2'h3;
        mov(1'b1, 3'h4, 32'h0bad_0bad);
        chk_flag(last_f, 1'b1);
        i_real_mode = 1'b1;
        rd_chk(3'h4, 32'hffff_f7f8, 32'hffff_ffff);
        chk_flag(last_f, 1'b0);
        i_real_mode = 1'b0;
        i_cpl = 2'h0;
        // tlb write into set 2, then lookups
        mov(1'b1, 3'h7, 32'habcd_e018);
        mov(1'b1, 3'h6, 32'h1234_5cc0);
        foreach (looks[i]) begin
            mov(1'b1, 3'h7, 32'h0000_0000);
            mov(1'b1, 3'h6, looks[i][32:1]);
            rd_chk(3'h7, {27'h0, looks[i][0], 4'h0}, 32'h0000_0010);
            if (looks[i][0]) begin
                rd_chk(3'h7, 32'habcd_e018, 32'hffff_fc7c);
                rd_chk(3'h6, 32'h1234_5cc1, 32'hffff_ffff);
            end
        end
        mov(1'b1, 3'h7, 32'habcd_e018);
        mov(1'b1, 3'h6, 32'h1234_54c0);
        mov(1'b1, 3'h6, 32'h1234_57e1);
        rd_chk(3'h7, 32'h0000_0000, 32'h0000_0010);
        // write with hit flag clear lands in a set of the block's own choosing
        mov(1'b1, 3'h7, 32'habcd_e000);
        mov(1'b1, 3'h6, 32'h1234_5cc0);
        mov(1'b1, 3'h6, 32'h1234_57e1);
        rd_chk(3'h7, 32'habcd_e010, 32'hffff_f010);
        // cache fill, write, read back, flush
        for (int k = 0; k < 4; k++) begin
            mov(1'b1, 3'h5, 32'(k) << 2);
            mov(1'b1, 3'h3, 32'hc0de_0000 + 32'(k));
        end
        mov(1'b1, 3'h4, 32'h1357_9450);
        mov(1'b1, 3'h5, 32'h0000_05a5);
        mov(1'b1, 3'h4, 32'h0000_0000);
        mov(1'b1, 3'h5, 32'h0000_05a6);
        rd_chk(3'h4, 32'h1357_9450, 32'hffff_fc78);
        for (int k = 0; k < 4; k++) begin
            mov(1'b1, 3'h5, 32'(k) << 2);
            rd_chk(3'h3, 32'hc0de_0000 + 32'(k), 32'hffff_ffff);
        end
        mov(1'b1, 3'h5, 32'h0000_05a7);
        mov(1'b1, 3'h5, 32'h0000_05a6);
        rd_chk(3'h4, 32'h0000_0000, 32'hffff_ffff);
        rd_chk(3'h3, 32'hc0de_0003, 32'hffff_ffff);
        // mid-run reset; a move during the flush is ignored
        @(posedge i_ref_clk);
        #1;
        i_rst = 1'b1;
        repeat (3) @(posedge i_ref_clk);
        #1;
        chk_flag(o_busy, 1'b1);
        chk_word(o_mov_rdata, 32'h0000_0000, 32'hffff_ffff);
        i_rst = 1'b0;
        i_mov_req = 1'b1;
        i_mov_wr = 1'b1;
        i_mov_sel = 3'h5;
        i_mov_wdata = 32'h0000_0ff0;
        @(posedge i_ref_clk);
        #1;
        i_mov_req = 1'b0;
        chk_flag(o_mov_done | o_mov_fault, 1'b0);
        wait_idle();
        rd_chk(3'h5, 32'h0000_0000, 32'hffff_ffff);
        rd_chk(3'h7, 32'h0000_0000, 32'hffff_ffff);
        give_verdict();
    end
endmodule : testbench
